// [hw/sadc_cfg.svh]
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// =====================================================================
// Converter and serial readout configuration
// =====================================================================

// Result width of one conversion.
`define SADC_RES_BITS 12

// Period of the block clock, which also serves as the internal
// conversion oscillator.
`define SADC_CLK_PERIOD_NS 100

// Least conversion time.
`define SADC_T_CONVERT_STROBE_NS 1400

// Strobe pulse counts, taken with the serial clock static.
`define SADC_PULSES_NAP 3'h2
`define SADC_PULSES_SLEEP 3'h4

// Reset values of the pin-facing state.
`define SADC_SDO_RST 1'h0
`define SADC_PULSE_CNT_RST 3'h0

`endif

// [hw/sadc_pkg.sv]
`include "sadc_cfg.svh"

package sadc_pkg;

    // =================================================================
    // Types
    // =================================================================

    typedef enum logic [1:0] {
        SADC_ACTIVE,
        SADC_NAP,
        SADC_SLEEP
    } sadc_pwr_t;

    typedef struct packed {
        logic convert_strobe_s1;
        logic convert_strobe_s2;
        logic convert_strobe_q;
        logic sck_s1;
        logic sck_s2;
        logic sck_q;
        logic start;
        logic [`SADC_RES_BITS-1:0] shift;
        logic sdo;
        logic sdo_oe;
        logic sampling;
        logic [2:0] pulse_cnt;
        sadc_pwr_t pwr;
    } sadc_state_t;

endpackage

// [hw/sadc_sar.sv]
`timescale 1ns/1ps
`default_nettype none

module sadc_sar #(
    parameter int WIDTH = 12,
    parameter int CONVERT_STROBE_CYCLES = 14
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Control.
    input wire logic i_start,
    // Latched comparator: high when the input is at or above the DAC.
    input wire logic i_cmp_high,
    // Results.
    output logic [WIDTH-1:0] o_dac_code,
    output logic [WIDTH-1:0] o_result,
    output logic o_busy,
    output logic o_done
);

    localparam int CW = $clog2(CONVERT_STROBE_CYCLES + 1);

    // =================================================================
    // Parameter check
    // =================================================================

    // Each bit takes one oscillator cycle, so the conversion window
    // must hold all of them.
    if (WIDTH < 1 || CONVERT_STROBE_CYCLES < WIDTH + 1) begin : g_bad_param
        $error("sadc_sar: conversion window too short for the width.");
    end

    typedef struct packed {
        logic [WIDTH-1:0] trial;
        logic [WIDTH-1:0] mask;
        logic [WIDTH-1:0] result;
        logic [CW-1:0] cnt;
        logic busy;
        logic done;
    } sadc_sar_t;

    localparam logic [WIDTH-1:0] TOP_BIT = {1'b1, {(WIDTH - 1){1'b0}}};
    localparam logic [CW-1:0] LAST = CW'(CONVERT_STROBE_CYCLES - 1);

    sadc_sar_t q;
    sadc_sar_t d;

    // =================================================================
    // Successive approximation
    // =================================================================

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (i_start) begin
            d.busy = 1'b1;
            d.cnt = '0;
            d.trial = TOP_BIT;
            d.mask = TOP_BIT;
        end else if (q.busy) begin
            d.cnt = q.cnt + CW'(1);
            if (q.mask != '0) begin
                d.mask = q.mask >> 1;
                d.trial = (i_cmp_high ? q.trial : (q.trial & ~q.mask))
                    | d.mask;
            end
            if (q.cnt == LAST) begin
                d.busy = 1'b0;
                d.done = 1'b1;
                d.result = q.trial;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_dac_code = q.trial;
    assign o_result = q.result;
    assign o_busy = q.busy;
    assign o_done = q.done;

endmodule

`default_nettype wire

// [hw/sadc_ctrl.sv]

`timescale 1ns/1ps
`default_nettype none

`include "sadc_cfg.svh"

module sadc_ctrl
    import sadc_pkg::*;
#(
    parameter int RES_BITS = `SADC_RES_BITS
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Host pins.
    input wire logic i_convert_strobe,
    input wire logic i_sck,
    output logic o_sdo,
    output logic o_sdo_oe,
    // Analog side.
    input wire logic i_cmp_high,
    output logic [RES_BITS-1:0] o_dac_code,
    output logic o_sample,
    output logic o_busy,
    // Power state.
    output logic o_nap,
    output logic o_sleep,
    output logic o_ref_on
);

    // =================================================================
    // Timing and parameter check
    // =================================================================

    // Least time, so the count rounds up.
    localparam int CONVERT_STROBE_CYCLES = (`SADC_T_CONVERT_STROBE_NS + `SADC_CLK_PERIOD_NS - 1)
        / `SADC_CLK_PERIOD_NS;

    // The state record is sized from the shared configuration, so the
    // width cannot be changed here alone.
    if (RES_BITS != `SADC_RES_BITS) begin : g_bad_width
        $error("sadc_ctrl: RES_BITS must match the configured width.");
    end

    // One trial per oscillator cycle plus the load of the result
    // register must fit inside the least conversion time, or the
    // host could read a result before the last bit is decided.
    if (CONVERT_STROBE_CYCLES < RES_BITS + 1) begin : g_bad_convert_strobe
        $error("sadc_ctrl: conversion time too short for the width.");
    end

    // =================================================================
    // Link limits
    // =================================================================

    // The host pins are oversampled by the block clock. Each pin level
    // must therefore last two block clock periods to pass the
    // synchroniser and be seen as an edge. The serial clock rate this
    // logic serves is bound by the block clock, not by the pad; a
    // faster block clock raises it towards the full link rate.
    //
    // The price of oversampling is latency: every pin event takes
    // three block clock cycles to reach the outputs, four from a strobe rise to o_busy, o_dac_code, o_nap, o_sleep and o_ref_on. A host that
    // captures on the rising serial clock edge after a falling one
    // sees settled data as long as the low phase covers that delay.
    if (`SADC_CLK_PERIOD_NS < 1) begin : g_bad_clk
        $error("sadc_ctrl: block clock period must be positive.");
    end

    sadc_state_t q;
    sadc_state_t d;
    logic [RES_BITS-1:0] result;
    logic convert_strobe_done;
    logic convert_strobe_rise;
    logic convert_strobe_fall;
    logic sck_rise;
    logic sck_fall;

    // =================================================================
    // Converter core
    // =================================================================

    sadc_sar #(
        .WIDTH(RES_BITS),
        .CONVERT_STROBE_CYCLES(CONVERT_STROBE_CYCLES)
    ) u_sar (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_start(q.start),
        .i_cmp_high(i_cmp_high),
        .o_dac_code(o_dac_code),
        .o_result(result),
        .o_busy(o_busy),
        .o_done(convert_strobe_done)
    );

    // =================================================================
    // Pin edge detection
    // =================================================================

    // Edges are found on the second synchroniser stage only.
    assign convert_strobe_rise = q.convert_strobe_s2 & ~q.convert_strobe_q;
    assign convert_strobe_fall = ~q.convert_strobe_s2 & q.convert_strobe_q;
    assign sck_rise = q.sck_s2 & ~q.sck_q;
    assign sck_fall = ~q.sck_s2 & q.sck_q;

    // =================================================================
    // Control
    // =================================================================

    always_comb begin
        d = q;
        d.convert_strobe_s1 = i_convert_strobe;
        d.convert_strobe_s2 = q.convert_strobe_s1;
        d.convert_strobe_q = q.convert_strobe_s2;
        d.sck_s1 = i_sck;
        d.sck_s2 = q.sck_s1;
        d.sck_q = q.sck_s2;
        d.start = convert_strobe_rise;

        // Sample-and-hold tracks while the strobe is low and holds
        // from the rise on.
        d.sampling = ~q.convert_strobe_s2;

        // Readout. A strobe that falls before the conversion ends
        // shifts out the previous result; the host must keep the
        // strobe high long enough. Serial clock falls while the data
        // pin is released are ignored, so a stray clock during the
        // conversion cannot advance the shift register.
        if (q.convert_strobe_s2) begin
            d.sdo_oe = 1'b0;
            d.sdo = `SADC_SDO_RST;
        end else if (convert_strobe_fall) begin
            // The result register updates only at the end of a
            // conversion, so a strobe that falls early sends the older result.
            d.sdo_oe = 1'b1;
            d.sdo = result[RES_BITS-1];
            d.shift = result << 1;
        end else if (sck_fall && q.sdo_oe) begin
            // Zeros shift in behind the data without limit.
            d.sdo = q.shift[RES_BITS-1];
            d.shift = q.shift << 1;
        end

        // Power modes. The strobe pulse count only grows while the
        // serial clock stays still; any clock rise restarts it.
        // A wake and a strobe count step in the same cycle resolve to
        // the wake, so a host that pulses the clock is never left in
        // a low-power state it did not ask for. The count saturates at
        // the sleep value so that extra pulses cannot wrap it back to
        // an active pattern. Every strobe pulse also starts a
        // conversion; the device converts even while it is being sent
        // into a low-power state.
        if (sck_rise) begin
            d.pulse_cnt = `SADC_PULSE_CNT_RST;
            d.pwr = SADC_ACTIVE;
        end else begin
            if (convert_strobe_rise && q.pulse_cnt != `SADC_PULSES_SLEEP) begin
                d.pulse_cnt = q.pulse_cnt + 3'h1;
            end
            if (q.pulse_cnt == `SADC_PULSES_SLEEP) begin
                d.pwr = SADC_SLEEP;
            end else if (q.pulse_cnt >= `SADC_PULSES_NAP &&
                         q.pwr == SADC_ACTIVE) begin
                d.pwr = SADC_NAP;
            end
            // The automatic nap after a conversion only leaves the
            // active state; it must never lift the device out of
            // sleep, where the reference is down.
            if (convert_strobe_done && d.pwr == SADC_ACTIVE) begin
                d.pwr = SADC_NAP;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================

    // The host pin outputs come straight from flip-flops, so the
    // data pin and its enable never glitch between clock edges.
    assign o_sdo = q.sdo;
    assign o_sdo_oe = q.sdo_oe;
    assign o_sample = q.sampling;
    assign o_nap = (q.pwr == SADC_NAP);
    assign o_sleep = (q.pwr == SADC_SLEEP);
    // Bandgap and reference buffer stay up in nap, down only in sleep.
    assign o_ref_on = (q.pwr != SADC_SLEEP);

endmodule

`default_nettype wire

// [test/sadc_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Pin timing checks
// ==========================================
module sadc_ctrl_asserts #(
    parameter int RES_BITS = 12
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Observed ports.
    input wire logic i_convert_strobe,
    input wire logic i_sck,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic [RES_BITS-1:0] o_dac_code,
    input wire logic o_sample,
    input wire logic o_busy,
    input wire logic o_nap,
    input wire logic o_sleep,
    input wire logic o_ref_on
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    a_strobe_hiz: assert property (i_convert_strobe [*3] |=> !o_sdo_oe)
        else $error("data pin driven while strobe high");
    a_idle_zero: assert property (!o_sdo_oe |-> !o_sdo)
        else $error("data value set while pin released");
    a_fall_enable: assert property ($fell(i_convert_strobe) |-> ##4 o_sdo_oe)
        else $error("data pin not enabled after strobe fall");
    a_fall_sample: assert property ($fell(i_convert_strobe) |-> ##[2:4] o_sample)
        else $error("sampling not started after strobe fall");
    a_rise_busy: assert property ($rose(i_convert_strobe) |-> ##[3:4] o_busy)
        else $error("conversion not started by strobe rise");
    a_busy_length: assert property ($rose(o_busy) |-> ##13 o_busy ##1 !o_busy)
        else $error("conversion length wrong");
    a_first_trial: assert property ($rose(o_busy) |-> o_dac_code == (1 << (RES_BITS-1)))
        else $error("first trial code is not mid scale");
    a_auto_nap: assert property ($fell(o_busy) |-> ##[0:1] (o_nap || o_sleep))
        else $error("no nap after conversion");
    a_ref_sleep: assert property (o_ref_on != o_sleep)
        else $error("reference state disagrees with sleep");
    a_sck_wake: assert property ($rose(i_sck) |-> ##[2:4] (!o_nap && !o_sleep))
        else $error("serial clock pulse did not wake");
endmodule

bind sadc_ctrl sadc_ctrl_asserts #(.RES_BITS(RES_BITS)) u_asserts (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_convert_strobe(i_convert_strobe),
    .i_sck(i_sck), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_dac_code(o_dac_code),
    .o_sample(o_sample), .o_busy(o_busy), .o_nap(o_nap), .o_sleep(o_sleep),
    .o_ref_on(o_ref_on)
);

`default_nettype wire

// [test/sadc_host.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Serial host model
// ==========================================
module sadc_host (
    // Clock.
    input wire logic i_clk,
    // Serial pins.
    input wire logic i_sdo,
    output logic o_strobe,
    output logic o_sck,
    // Captured word.
    output logic [15:0] o_word,
    output logic o_word_vld
);
    initial begin
        o_strobe = 1'b0;
        o_sck = 1'b0;
        o_word = 16'h0000;
        o_word_vld = 1'b0;
    end

    // The strobe stays high past the conversion and the clock stays still.
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            o_strobe <= 1'b1;
            repeat (20) @(posedge i_clk);
            o_strobe <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask

    // A clock of 800 ns, far below the fastest allowed rate.
    task automatic wake();
        o_sck <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_sck <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask

    // The bit is taken late in the high phase, long after it settled.
    task automatic frame(input int n);
        logic [15:0] w;
        w = 16'h0000;
        pulses(1);
        for (int i = 0; i < n; i++) begin
            o_sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            w = {w[14:0], i_sdo};
            o_sck <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
        o_word <= w;
        o_word_vld <= 1'b1;
        @(posedge i_clk);
        o_word_vld <= 1'b0;
    endtask
endmodule

`default_nettype wire

// [test/sadc_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Testbench
// ==========================================
module sadc_ctrl_tb_top;
    logic clk, rst_b, strobe, sck, sdo, oe, sample, busy, nap, sleep, ref_on;
    logic sdo_pin, word_vld;
    logic [11:0] dac, vin, v;
    logic [15:0] word;
    logic [15:0] exq[$];
    int n_fail = 0;
    int comparisons = 0;

    // A released pin shows the opposite level so stale data cannot pass.
    assign sdo_pin = oe ? sdo : !sdo;

    sadc_ctrl u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_convert_strobe(strobe),
        .i_sck(sck), .o_sdo(sdo), .o_sdo_oe(oe), .i_cmp_high(vin >= dac),
        .o_dac_code(dac), .o_sample(sample), .o_busy(busy), .o_nap(nap),
        .o_sleep(sleep), .o_ref_on(ref_on));
    sadc_host u_host (.i_clk(clk), .i_sdo(sdo_pin), .o_strobe(strobe),
        .o_sck(sck), .o_word(word), .o_word_vld(word_vld));

    task automatic complete_run();
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic convert(input int i);
        v = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($urandom);
        vin <= v;
        exq.push_back({v, 4'h0} >> (16 - (13 + i % 4)));
        u_host.frame(13 + i % 4);
    endtask

    always @(posedge clk) begin
        if (word_vld === 1'b1)
            check("word", word, exq.pop_front());
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        vin = 12'h000;
        void'($urandom(96020));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 6; i++)
            convert(i);
        u_host.pulses(2);
        check("nap", nap, 1'b1);
        check("sleep", sleep, 1'b0);
        u_host.wake();
        check("nap", nap, 1'b0);
        u_host.pulses(4);
        check("sleep", sleep, 1'b1);
        check("ref_on", ref_on, 1'b0);
        u_host.wake();
        check("sleep", sleep, 1'b0);
        check("ref_on", ref_on, 1'b1);
        // Reference recovery is shortened; the model has no analog settling.
        repeat (100) @(posedge clk);
        convert(6);
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule

`default_nettype wire
